// ===== design/acl_params.svh
// Constants for the layer-4 access-control match and action block.
`ifndef ACL_PARAMS_SVH
`define ACL_PARAMS_SVH

// ------------------------------------------------------------------
// Register offsets.
// ------------------------------------------------------------------
`define ACL_OFS_CFG       8'h00
`define ACL_OFS_BOUND     8'h04
`define ACL_OFS_TCPF      8'h08
`define ACL_OFS_ACT       8'h0c
`define ACL_OFS_EGRESS    8'h10
`define ACL_OFS_STATUS    8'h14

// ------------------------------------------------------------------
// Field positions (least significant bit of each field).
// ------------------------------------------------------------------
`define ACL_CFG_LAYER     0
`define ACL_CFG_CMP       2
`define ACL_CFG_SIDE      4
`define ACL_CFG_POL       5
`define ACL_CFG_PRC       6
`define ACL_CFG_TCPEN     8
`define ACL_BOUND_LO      0
`define ACL_BOUND_HI      16
`define ACL_TCPF_PROTO    0
`define ACL_TCPF_FLAG     8
`define ACL_TCPF_MASK     16
`define ACL_ACT_MERGE     0
`define ACL_ACT_REMARK    2
`define ACL_ACT_RMK_EN    5
`define ACL_ACT_PRIO      6
`define ACL_ACT_OVR_MODE  9
`define ACL_ACT_TICK      11
`define ACL_ACT_ALG       12
`define ACL_STAT_ARMED    16
`define ACL_STAT_MATCH    17

// ------------------------------------------------------------------
// Reset values and protocol numbers.
// ------------------------------------------------------------------
`define ACL_REG_RST       32'h0000_0000
`define ACL_PROTO_TCP     8'h06
`define ACL_PROTO_UDP     8'h11

// ------------------------------------------------------------------
// Timing.
// ------------------------------------------------------------------
`define ACL_CLK_MHZ       25
`define ACL_TICK_US       1
`define ACL_US_PER_MS     1000

`endif

// ===== design/acl_pkg.sv
// Types shared by the layer-4 access-control match and action block.
package acl_pkg;

	// Rule layer select encoding.
	typedef enum logic [1:0] {
		ACL_LAYER_OFF = 2'b00,
		ACL_LAYER_L2  = 2'b01,
		ACL_LAYER_L3  = 2'b10,
		ACL_LAYER_L4  = 2'b11
	} acl_layer_t;

	// Layer-4 compare select encoding.
	typedef enum logic [1:0] {
		ACL_CMP_PROTO = 2'b00,
		ACL_CMP_TCP   = 2'b01,
		ACL_CMP_UDP   = 2'b10,
		ACL_CMP_SEQ   = 2'b11
	} acl_cmp_t;

	// Port range compare encoding.
	typedef enum logic [1:0] {
		ACL_PRC_OFF    = 2'b00,
		ACL_PRC_EITHER = 2'b01,
		ACL_PRC_INSIDE = 2'b10,
		ACL_PRC_OUTSIDE = 2'b11
	} acl_prc_t;

	// Priority override mode encoding.
	typedef enum logic [1:0] {
		ACL_OVR_QOS   = 2'b00,
		ACL_OVR_ABOVE = 2'b01,
		ACL_OVR_BELOW = 2'b10,
		ACL_OVR_FORCE = 2'b11
	} acl_ovr_t;

	// Forward map merge encoding.
	typedef enum logic [1:0] {
		ACL_MERGE_KEEP    = 2'b00,
		ACL_MERGE_OR      = 2'b01,
		ACL_MERGE_AND     = 2'b10,
		ACL_MERGE_REPLACE = 2'b11
	} acl_merge_t;

endpackage : acl_pkg

// ===== design/acl_l4_match_and_action.sv
// Layer-4 rule evaluation, rule actions and count mode for one switch port.
`timescale 1ns/1ns
`include "acl_params.svh"

// Functional notes
// - Layer select: off, L2/count, L3, L4.
// - L4 compare: protocol, TCP port, UDP port, sequence.
// - Side bit picks destination or source field.
// - Polarity picks equal or not-equal as true.
// - Bounds hold two ports or one sequence.
// - Range 00 off, 01 equals either bound.
// - Range 10 inside, 11 outside bounds.
// - Protocol byte compared with stored value.
// - Flag enable adds flag compare to result.
// - Ignore mask skips flag bits set one.
// - Priority 00 keeps QoS, 11 forces override.
// - Priority 01 if higher, 10 if lower.
// - Remark enable replaces VLAN PCP bits.
// - Merge 00 keeps map, 01 ORs mask.
// - Merge 10 ANDs mask, 11 replaces map.
// - Mask bit n steers port n+1.
// - Tick base is microsecond or millisecond.
// - Timeout down-counter interrupts on expiry.
// - Packet up-counter interrupts at terminal count.
// - Count mode uses action fields as count.
// - Only count mode raises the port interrupt.
module acl_l4_match_and_action
	import acl_pkg::*;
#(
	parameter int NUM_PORTS = 7,
	parameter int US_PER_MS = `ACL_US_PER_MS
) (
	input  wire logic                 ref_clk_i,
	input  wire logic                 rst_b_i,
	input  wire logic [7:0]           reg_addr_i,
	input  wire logic [31:0]          reg_wdata_i,
	input  wire logic                 reg_wr_i,
	input  wire logic                 reg_rd_i,
	output logic      [31:0]          reg_rdata_o,
	input  wire logic                 pkt_valid_i,
	input  wire logic                 pkt_l2_hit_i,
	input  wire logic [7:0]           pkt_ip_proto_i,
	input  wire logic [15:0]          pkt_src_port_i,
	input  wire logic [15:0]          pkt_dst_port_i,
	input  wire logic [31:0]          pkt_tcp_seq_i,
	input  wire logic [7:0]           pkt_tcp_flags_i,
	input  wire logic [2:0]           pkt_qos_prio_i,
	input  wire logic [2:0]           pkt_pcp_i,
	input  wire logic [NUM_PORTS-1:0] pkt_fwd_map_i,
	output logic                      res_valid_o,
	output logic                      res_match_o,
	output logic      [2:0]           res_prio_o,
	output logic      [2:0]           res_pcp_o,
	output logic      [NUM_PORTS-1:0] res_fwd_map_o,
	output logic                      count_irq_o
);

	// ------------------------------------------------------------------
	// Timing constants.
	// ------------------------------------------------------------------
	localparam int US_CYC = `ACL_CLK_MHZ * `ACL_TICK_US;  // Cycles per microsecond.
	localparam int US_W   = $clog2(US_CYC + 1);          // Width of the cycle counter.
	localparam int MS_W   = $clog2(US_PER_MS + 1);       // Width of the microsecond counter.

	// ------------------------------------------------------------------
	// Registers and decoded fields.
	// ------------------------------------------------------------------
	logic [31:0]          cfg_reg;          // Rule selects and compare options.
	logic [31:0]          bound_reg;        // Port bounds or sequence number.
	logic [31:0]          tcpf_reg;         // Protocol, flag value and ignore mask.
	logic [31:0]          act_reg;          // Action fields, tick base, algorithm.
	logic [NUM_PORTS-1:0] egress_mask_reg;  // Egress port mask.
	acl_layer_t           layer;            // Rule layer select.
	acl_cmp_t             cmp_sel;          // Compare select.
	acl_prc_t             prc;              // Port range compare.
	acl_ovr_t             ovr_mode;         // Priority override mode.
	acl_merge_t           merge_mode;       // Forward map merge.
	logic                 side;             // Source when set.
	logic                 pol;              // Equal is true when set.
	logic                 tcp_en;           // Flag compare enable.
	logic [7:0]           proto_val;        // Stored protocol value.
	logic [7:0]           flag_val;         // Stored flag value.
	logic [7:0]           flag_mask;        // Flag ignore mask.
	logic [2:0]           ovr_prio;         // Override priority.
	logic [2:0]           remark_value;     // Remark priority.
	logic                 remark_en;        // Remark enable.
	logic                 tick_base_select; // Millisecond base when set.
	logic                 counter_algorithm; // Packet count when set.
	logic [10:0]          count_value;      // Count mode value.
	logic                 count_mode;       // Rule is in count mode.

	assign layer             = acl_layer_t'(cfg_reg[`ACL_CFG_LAYER +: 2]);
	assign cmp_sel           = acl_cmp_t'(cfg_reg[`ACL_CFG_CMP +: 2]);
	assign side              = cfg_reg[`ACL_CFG_SIDE];
	assign pol               = cfg_reg[`ACL_CFG_POL];
	assign prc               = acl_prc_t'(cfg_reg[`ACL_CFG_PRC +: 2]);
	assign tcp_en            = cfg_reg[`ACL_CFG_TCPEN];
	assign proto_val         = tcpf_reg[`ACL_TCPF_PROTO +: 8];
	assign flag_val          = tcpf_reg[`ACL_TCPF_FLAG +: 8];
	assign flag_mask         = tcpf_reg[`ACL_TCPF_MASK +: 8];
	assign merge_mode        = acl_merge_t'(act_reg[`ACL_ACT_MERGE +: 2]);
	assign remark_value      = act_reg[`ACL_ACT_REMARK +: 3];
	assign remark_en         = act_reg[`ACL_ACT_RMK_EN];
	assign ovr_prio          = act_reg[`ACL_ACT_PRIO +: 3];
	assign ovr_mode          = acl_ovr_t'(act_reg[`ACL_ACT_OVR_MODE +: 2]);
	assign tick_base_select  = act_reg[`ACL_ACT_TICK];
	assign counter_algorithm = act_reg[`ACL_ACT_ALG];
	// The action fields, taken together from priority mode down, form the count.
	assign count_value = act_reg[`ACL_ACT_MERGE +: 11];
	assign count_mode  = (layer == ACL_LAYER_L2) && (cmp_sel == ACL_CMP_PROTO);

	// ------------------------------------------------------------------
	// Register writes.
	// ------------------------------------------------------------------
	// Config, bound, flag and action offsets store the full word, egress keeps NUM_PORTS bits; other writes are dropped.
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cfg_reg         <= `ACL_REG_RST;
			bound_reg       <= `ACL_REG_RST;
			tcpf_reg        <= `ACL_REG_RST;
			act_reg         <= `ACL_REG_RST;
			egress_mask_reg <= '0;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				`ACL_OFS_CFG:    cfg_reg         <= reg_wdata_i;
				`ACL_OFS_BOUND:  bound_reg       <= reg_wdata_i;
				`ACL_OFS_TCPF:   tcpf_reg        <= reg_wdata_i;
				`ACL_OFS_ACT:    act_reg         <= reg_wdata_i;
				`ACL_OFS_EGRESS: egress_mask_reg <= reg_wdata_i[NUM_PORTS-1:0];
				default:         cfg_reg         <= cfg_reg;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Rule evaluation.
	// ------------------------------------------------------------------
	logic [15:0] sel_port;   // Packet port picked by the side bit.
	logic        port_hit;   // Port range compare result.
	logic        type_ok;    // Packet carries the compared protocol.
	logic        field_hit;  // Selected field matches stored value or port range.
	logic        flags_ok;   // Flag compare passes or is off.
	logic        rule_hit;   // Rule result true.

	// Combines field compare, polarity and flag compare into one result.
	always_comb begin
		sel_port = side ? pkt_src_port_i : pkt_dst_port_i;
		case (prc)
			ACL_PRC_OFF:    port_hit = 1'b1;
			ACL_PRC_EITHER: port_hit = (sel_port == bound_reg[`ACL_BOUND_HI +: 16]) ||
			                           (sel_port == bound_reg[`ACL_BOUND_LO +: 16]);
			ACL_PRC_INSIDE: port_hit = (sel_port >= bound_reg[`ACL_BOUND_LO +: 16]) &&
			                           (sel_port <= bound_reg[`ACL_BOUND_HI +: 16]);
			default:        port_hit = (sel_port < bound_reg[`ACL_BOUND_LO +: 16]) ||
			                           (sel_port > bound_reg[`ACL_BOUND_HI +: 16]);
		endcase
		case (cmp_sel)
			ACL_CMP_PROTO: begin
				type_ok   = 1'b1;
				field_hit = (pkt_ip_proto_i == proto_val);
			end
			ACL_CMP_TCP: begin
				type_ok   = (pkt_ip_proto_i == `ACL_PROTO_TCP);
				field_hit = port_hit;
			end
			ACL_CMP_UDP: begin
				type_ok   = (pkt_ip_proto_i == `ACL_PROTO_UDP);
				field_hit = port_hit;
			end
			default: begin
				type_ok   = (pkt_ip_proto_i == `ACL_PROTO_TCP);
				field_hit = (pkt_tcp_seq_i == bound_reg);
			end
		endcase
		// Masked bits are forced equal so they never spoil the compare.
		flags_ok = !tcp_en || ((pkt_ip_proto_i == `ACL_PROTO_TCP) &&
		           (((pkt_tcp_flags_i ^ flag_val) & ~flag_mask) == 8'h00));
		// Only layer-4 rules match here; off, layer-2 and layer-3 never do.
		rule_hit = (layer == ACL_LAYER_L4) && type_ok &&
		           (pol ? field_hit : !field_hit) && flags_ok;
	end

	// ------------------------------------------------------------------
	// Actions.
	// ------------------------------------------------------------------
	logic [2:0]           prio_next;  // Priority after override.
	logic [2:0]           pcp_next;   // PCP after remark.
	logic [NUM_PORTS-1:0] fwd_next;   // Forwarding map after merge.

	// Applies override, remark and merge only on a true rule result.
	always_comb begin
		prio_next = pkt_qos_prio_i;
		pcp_next  = pkt_pcp_i;
		fwd_next  = pkt_fwd_map_i;
		if (rule_hit) begin
			case (ovr_mode)
				ACL_OVR_QOS:   prio_next = pkt_qos_prio_i;
				ACL_OVR_ABOVE: if (ovr_prio > pkt_qos_prio_i) prio_next = ovr_prio;
				ACL_OVR_BELOW: if (ovr_prio < pkt_qos_prio_i) prio_next = ovr_prio;
				default:      prio_next = ovr_prio;
			endcase
			if (remark_en) begin
				pcp_next = remark_value;
			end
			// Mask bit n lines up with map bit n, which is port n+1.
			case (merge_mode)
				ACL_MERGE_KEEP: fwd_next = pkt_fwd_map_i;
				ACL_MERGE_OR:   fwd_next = pkt_fwd_map_i | egress_mask_reg;
				ACL_MERGE_AND:  fwd_next = pkt_fwd_map_i & egress_mask_reg;
				default:     fwd_next = egress_mask_reg;
			endcase
		end
	end

	// Registers the per-packet result one cycle after the packet.
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			res_valid_o   <= 1'b0;
			res_match_o   <= 1'b0;
			res_prio_o    <= 3'h0;
			res_pcp_o     <= 3'h0;
			res_fwd_map_o <= '0;
		end else begin
			res_valid_o   <= pkt_valid_i;
			res_match_o   <= pkt_valid_i && rule_hit;
			res_prio_o    <= prio_next;
			res_pcp_o     <= pcp_next;
			res_fwd_map_o <= fwd_next;
		end
	end

	// ------------------------------------------------------------------
	// Time base.
	// ------------------------------------------------------------------
	logic [US_W-1:0] us_cnt_reg;  // Cycle counter within a microsecond.
	logic [MS_W-1:0] ms_cnt_reg;  // Microsecond counter within a millisecond.
	logic            us_tick;     // One-cycle pulse each microsecond.
	logic            ms_tick;     // One-cycle pulse each millisecond.
	logic            unit_tick;   // Selected count unit.

	assign us_tick   = (us_cnt_reg == US_W'(US_CYC - 1));
	assign ms_tick   = us_tick && (ms_cnt_reg == MS_W'(US_PER_MS - 1));
	assign unit_tick = tick_base_select ? ms_tick : us_tick;

	// Free-running dividers; the tick is only consumed in timeout mode.
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			us_cnt_reg <= '0;
			ms_cnt_reg <= '0;
		end else begin
			us_cnt_reg <= us_tick ? '0 : us_cnt_reg + US_W'(1);
			if (ms_tick) begin
				ms_cnt_reg <= '0;
			end else if (us_tick) begin
				ms_cnt_reg <= ms_cnt_reg + MS_W'(1);
			end
		end
	end

	// ------------------------------------------------------------------
	// Count mode.
	// ------------------------------------------------------------------
	logic [10:0] cnt_reg;    // Down or up counter.
	logic        armed_reg;  // Timeout running.
	logic        qualify;    // Qualifying packet in count mode.

	assign qualify = pkt_valid_i && count_mode && pkt_l2_hit_i;

	// Timeout mode reloads on each qualifying packet; packet mode counts to the value.
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_reg     <= 11'h000;
			armed_reg   <= 1'b0;
			count_irq_o <= 1'b0;
		end else begin
			count_irq_o <= 1'b0;
			if (!count_mode) begin
				// Filtering modes never raise the interrupt.
				cnt_reg   <= 11'h000;
				armed_reg <= 1'b0;
			end else if (!counter_algorithm) begin
				if (qualify) begin
					cnt_reg   <= count_value;
					armed_reg <= 1'b1;
				end else if (armed_reg && unit_tick) begin
					if (cnt_reg <= 11'h001) begin
						cnt_reg     <= 11'h000;
						armed_reg   <= 1'b0;
						count_irq_o <= 1'b1;
					end else begin
						cnt_reg <= cnt_reg - 11'h001;
					end
				end
			end else if (qualify) begin
				armed_reg <= 1'b0;
				if (cnt_reg + 11'h001 == count_value) begin
					cnt_reg     <= 11'h000;
					count_irq_o <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg + 11'h001;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Register reads.
	// ------------------------------------------------------------------
	// Read data stand only in the cycle after the strobe; otherwise zero.
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			reg_rdata_o <= `ACL_REG_RST;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				`ACL_OFS_CFG:    reg_rdata_o <= cfg_reg;
				`ACL_OFS_BOUND:  reg_rdata_o <= bound_reg;
				`ACL_OFS_TCPF:   reg_rdata_o <= tcpf_reg;
				`ACL_OFS_ACT:    reg_rdata_o <= act_reg;
				`ACL_OFS_EGRESS: reg_rdata_o <= 32'(egress_mask_reg);
				`ACL_OFS_STATUS: begin
					reg_rdata_o                  <= 32'(cnt_reg);
					reg_rdata_o[`ACL_STAT_ARMED] <= armed_reg;
					reg_rdata_o[`ACL_STAT_MATCH] <= res_match_o;
				end
				default:         reg_rdata_o <= `ACL_REG_RST;
			endcase
		end else begin
			reg_rdata_o <= `ACL_REG_RST;
		end
	end

	// ------------------------------------------------------------------
	// Assertions.
	// ------------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);

	a_off_no_match: assert property (
		pkt_valid_i && (layer != ACL_LAYER_L4) |=> !res_match_o && res_fwd_map_o == $past(pkt_fwd_map_i))
		else $error("non layer-4 rule produced a match");
	a_proto_polarity: assert property (
		pkt_valid_i && layer == ACL_LAYER_L4 && cmp_sel == ACL_CMP_PROTO && !tcp_en
		|=> res_match_o == ($past(pol) == ($past(pkt_ip_proto_i) == $past(proto_val))))
		else $error("protocol compare polarity wrong");
	a_range_inside: assert property (
		pkt_valid_i && layer == ACL_LAYER_L4 && cmp_sel == ACL_CMP_UDP && pol && !tcp_en &&
		prc == ACL_PRC_INSIDE && pkt_ip_proto_i == `ACL_PROTO_UDP && !side &&
		pkt_dst_port_i > bound_reg[`ACL_BOUND_HI +: 16] |=> !res_match_o)
		else $error("port above range matched");
	a_flag_mask: assert property (
		pkt_valid_i && tcp_en &&
		(((pkt_tcp_flags_i ^ flag_val) & ~flag_mask) != 8'h00) |=> !res_match_o)
		else $error("unmasked flag mismatch matched");
	a_prio_force: assert property (
		pkt_valid_i && rule_hit && ovr_mode == ACL_OVR_FORCE |=> res_prio_o == $past(ovr_prio))
		else $error("forced priority not applied");
	a_prio_nohit: assert property (
		!rule_hit |=> res_prio_o == $past(pkt_qos_prio_i) && res_pcp_o == $past(pkt_pcp_i))
		else $error("action applied without a match");
	a_remark_pcp: assert property (
		rule_hit && remark_en |=> res_pcp_o == $past(remark_value))
		else $error("remark not applied");
	a_fwd_or: assert property (
		rule_hit && merge_mode == ACL_MERGE_OR |=>
		res_fwd_map_o == ($past(pkt_fwd_map_i) | $past(egress_mask_reg)))
		else $error("forward map OR wrong");
	a_fwd_replace: assert property (
		rule_hit && merge_mode == ACL_MERGE_REPLACE |=> res_fwd_map_o == $past(egress_mask_reg))
		else $error("forward map replace wrong");
	a_irq_cause: assert property (
		count_irq_o |-> $past(count_mode) && ($past(qualify) || $past(unit_tick)))
		else $error("interrupt outside count mode");
	a_reload_count: assert property (
		qualify && !counter_algorithm |=> cnt_reg == $past(count_value) && armed_reg)
		else $error("down-counter not reloaded");
	a_timeout_fire: assert property (
		count_mode && !counter_algorithm && armed_reg && cnt_reg == 11'h001 && unit_tick && !qualify
		|=> count_irq_o ##1 !count_irq_o)
		else $error("timeout interrupt missing");

	c_l4_match:   cover property (pkt_valid_i && rule_hit && layer == ACL_LAYER_L4);
	c_timeout:    cover property (count_irq_o && !counter_algorithm);
	c_pkt_count:  cover property (count_irq_o && counter_algorithm);

endmodule : acl_l4_match_and_action

// ===== dv/acl_pipe_model.sv
// Model of the ingress parser and lookup stage that feeds the rule block.
`timescale 1ns/1ns

module acl_pipe_model (
	input  wire logic        ref_clk_i,
	input  wire logic        req_i,
	input  wire logic [61:0] hdr_i,
	output logic             valid_o,
	output logic      [61:0] hdr_o
);
	// ----------------
	// Header launch
	// ----------------
	// Start idle so nothing looks like a packet before the first request.
	initial begin
		valid_o = 1'b0;
		hdr_o   = 62'h0;
	end

	// One header per request, held for one cycle.
	// Between packets the fields flip every cycle, so stale data never matches by luck.
	always @(posedge ref_clk_i) begin
		valid_o <= req_i;
		hdr_o   <= req_i ? hdr_i : ~hdr_o;
	end
endmodule : acl_pipe_model

// ===== dv/testbench.sv
// Self-checking bench for the layer-4 rule, action and count logic.
`timescale 1ns/1ns
`include "acl_params.svh"

module testbench;
	// ----------------
	// Stimulus and observation
	// ----------------
	// Each row holds the rule config, the packet fields and the expected match.
	typedef struct packed {
		logic [11:0] cfg;
		logic [7:0]  pr;
		logic [15:0] sp;
		logic [15:0] dp;
		logic [7:0]  fl;
		logic [3:0]  m;
	} acl_row_t;
	acl_row_t    rows [23] = '{
		64'h023_11_0000_0000_00_1, 64'h023_06_0000_0000_00_0, 64'h003_06_0000_0000_00_1,
		64'h003_11_0000_0000_00_0, 64'h020_11_0000_0000_00_0, 64'h021_11_0000_0000_00_0,
		64'h022_11_0000_0000_00_0, 64'h067_06_0000_00c8_00_1, 64'h067_06_0000_0096_00_0,
		64'h077_06_0064_0007_00_1, 64'h0a7_06_0000_0064_00_1, 64'h0a7_06_0000_00c9_00_0,
		64'h0e7_06_0000_0063_00_1, 64'h0e7_06_0000_00c8_00_0, 64'h06b_11_0000_0064_00_1,
		64'h06b_06_0000_0064_00_0, 64'h02f_06_00c8_0064_00_1, 64'h02f_06_00c9_0064_00_0,
		64'h103_06_0000_0000_1f_1, 64'h103_06_0000_0000_22_0, 64'h023_11_0000_0000_22_1,
		64'h027_06_0000_1234_00_1, 64'h02e_11_0000_0000_00_0};
	logic        clk   = 1'b0;    // Core clock.
	logic        rst_b = 1'b0;    // Reset, active low.
	logic [7:0]  addr  = 8'h00;   // Register address.
	logic [31:0] wdata = 32'h0;   // Register write data.
	logic        wr    = 1'b0;    // Write strobe.
	logic        rd    = 1'b0;    // Read strobe.
	logic        req   = 1'b0;    // Packet request to the model.
	logic [61:0] hdr   = 62'h0;   // Packet fields to the model.
	logic        pv;              // Packet valid from the model.
	logic [61:0] ph;              // Packet fields from the model.
	logic [31:0] rdata;           // Register read data.
	logic        rv, rm, irq;     // Result valid, match and count interrupt.
	logic [2:0]  rp, rc, qo, ep;  // Priority, PCP, QoS input, expected priority.
	logic [6:0]  rf, ef;          // Result map and expected map.
	logic [1:0]  ovr, mrg;        // Override mode and merge mode under test.
	int          n_fail = 0;
	int          total_checks = 0;
	int          cyc = 0;
	int          n_irq = 0;
	int          n0;

	always #20 clk = ~clk;

	acl_pipe_model pipe (.ref_clk_i(clk), .req_i(req), .hdr_i(hdr), .valid_o(pv), .hdr_o(ph));
	acl_l4_match_and_action #(.NUM_PORTS(7), .US_PER_MS(4)) uut (
		.ref_clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .pkt_valid_i(pv),
		.pkt_l2_hit_i(ph[61]), .pkt_ip_proto_i(ph[60:53]), .pkt_src_port_i(ph[52:37]),
		.pkt_dst_port_i(ph[36:21]), .pkt_tcp_seq_i(ph[52:21]), .pkt_tcp_flags_i(ph[20:13]),
		.pkt_qos_prio_i(ph[12:10]), .pkt_pcp_i(ph[9:7]), .pkt_fwd_map_i(ph[6:0]),
		.res_valid_o(rv), .res_match_o(rm), .res_prio_o(rp), .res_pcp_o(rc),
		.res_fwd_map_o(rf), .count_irq_o(irq));

	// Counts interrupt pulses where they are settled and cuts a hang short.
	always @(negedge clk) begin
		cyc++;
		if (irq === 1'b1)
			n_irq++;
		if (cyc == 5000) begin
			n_fail++;
			conclude();
		end
	end

	// ----------------
	// Tasks
	// ----------------
	task chk(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("MISMATCH t=%0t %s", $time, msg);
		end
	endtask : chk

	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	// Read data stands only in the cycle after the strobe.
	task rd_reg(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdata === e, "read data");
	endtask : rd_reg

	// The model launches one edge after the request; the result follows one edge later.
	task pkt(input logic [61:0] h, input logic em, input logic [12:0] er);
		@(posedge clk);
		req <= 1'b1;
		hdr <= h;
		@(posedge clk);
		req <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		chk(rv === 1'b1 && rm === em && {rp, rc, rf} === er, "packet result");
	endtask : pkt

	task conclude;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude

	// ----------------
	// Main sequence
	// ----------------
	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		wr_reg(`ACL_OFS_BOUND, 32'h00c8_0064);
		wr_reg(`ACL_OFS_TCPF, 32'h000f_1211);
		wr_reg(`ACL_OFS_ACT, 32'h0000_07b7);
		wr_reg(`ACL_OFS_EGRESS, 32'h0000_0055);
		for (int i = 0; i < 23; i++) begin
			wr_reg(`ACL_OFS_CFG, {20'h0, rows[i].cfg});
			pkt({1'b0, rows[i].pr, rows[i].sp, rows[i].dp, rows[i].fl, 13'h052a}, rows[i].m[0],
				rows[i].m[0] ? 13'h1ad5 : 13'h052a);
		end
		rd_reg(`ACL_OFS_CFG, 32'h0000_002e);
		rd_reg(8'h18, 32'h0);
		// Sweep every override and merge mode against a matching rule.
		wr_reg(`ACL_OFS_CFG, 32'h0000_0023);
		for (int i = 0; i < 16; i++) begin
			ovr = i[3:2];
			mrg = i[1:0];
			qo = i[0] ? 3'h2 : 3'h5;
			ep = (ovr == 2'b11 || (ovr == 2'b01 && qo < 3'h3) || (ovr == 2'b10 && qo > 3'h3)) ? 3'h3 : qo;
			ef = (mrg == 2'b00) ? 7'h2b : (mrg == 2'b01) ? 7'h7f : (mrg == 2'b10) ? 7'h01 : 7'h55;
			wr_reg(`ACL_OFS_ACT, {21'h0, ovr, 3'h3, i[1], 3'h5, mrg});
			pkt({49'h11_0000_0000_00, qo, 10'h12b}, 1'b1,
				{ep, i[1] ? 3'h5 : 3'h2, ef});
		end
		chk(n_irq == 0, "interrupt outside count mode");
		// Packet count of two: the second qualifying packet fires once.
		wr_reg(`ACL_OFS_ACT, 32'h0000_1002);
		wr_reg(`ACL_OFS_CFG, 32'h0000_0001);
		pkt(62'h2000_0000_0000_052a, 1'b0, 13'h052a);
		pkt(62'h0000_0000_0000_052a, 1'b0, 13'h052a);
		repeat (3) @(posedge clk);
		chk(n_irq == 0, "early count interrupt");
		pkt(62'h2000_0000_0000_052a, 1'b0, 13'h052a);
		repeat (3) @(posedge clk);
		chk(n_irq == 1, "count interrupt");
		// Microsecond timeout of three, reloaded by each qualifying packet.
		wr_reg(`ACL_OFS_ACT, 32'h0000_0003);
		for (int i = 0; i < 3; i++) begin
			pkt(62'h2000_0000_0000_052a, 1'b0, 13'h052a);
			repeat (40) @(posedge clk);
			chk(n_irq == 1, "timeout too early");
		end
		repeat (50) @(posedge clk);
		chk(n_irq == 2, "timeout interrupt");
		// Millisecond base with count two, shortened to four microseconds.
		wr_reg(`ACL_OFS_ACT, 32'h0000_0802);
		pkt(62'h2000_0000_0000_052a, 1'b0, 13'h052a);
		repeat (95) @(posedge clk);
		chk(n_irq == 2, "slow tick too early");
		repeat (120) @(posedge clk);
		chk(n_irq == 3, "slow tick timeout");
		// A reset in mid-run turns the rule off again.
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		rd_reg(`ACL_OFS_CFG, 32'h0);
		conclude();
	end
endmodule : testbench
